// file: pkg/cmd_engine_pkg.sv
`default_nettype none
package cmd_engine_pkg;
    typedef logic [4:0] idx_t;

    // input and output buffers: type, count, 18 payload, 2 check bytes
    localparam int unsigned BUF_DEPTH = 22;
    localparam idx_t        BUF_LAST  = 5'h15;
    localparam idx_t        IDX_ZERO  = 5'h00;
    localparam idx_t        IDX_ONE   = 5'h01;
    localparam idx_t        IDX_PAY0  = 5'h02;
    localparam idx_t        USER_LAST = 5'h11;

    localparam logic [7:0] MAX_LEN      = 8'h12;
    localparam logic [7:0] PING_MAX_LEN = 8'h10;
    localparam logic [7:0] BLOCK_LEN    = 8'h10;
    localparam logic [7:0] ZERO_LEN     = 8'h00;
    localparam logic [7:0] FRAME_EXTRA  = 8'h04;

    localparam logic [7:0] CMD_PING     = 8'h00;
    localparam logic [7:0] CMD_VERSION  = 8'h01;
    localparam logic [7:0] CMD_USER_WR  = 8'h02;
    localparam logic [7:0] CMD_USER_RD  = 8'h03;
    localparam logic [7:0] TYPE_LOW     = 8'h3F;
    localparam logic [7:0] RESP_FLAG    = 8'h40;
    localparam logic [7:0] ERR_FLAG     = 8'hC0;

    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;

    localparam logic [6:0] DEFAULT_ADDR = 7'h2A;
    localparam int unsigned USER_BYTES  = 16;

    // version text, value arbitrary: "LCDMOD:h0.0,x0.0"
    localparam logic [127:0] VERSION_STR = 128'h4C43_444D_4F44_3A68_302E_302C_7830_2E30;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CHECK  = 3'b001,
        ST_CRC_LO = 3'b010,
        ST_CRC_HI = 3'b011,
        ST_STORE  = 3'b100,
        ST_BUILD  = 3'b101,
        ST_PUT_LO = 3'b110,
        ST_PUT_HI = 3'b111
    } eng_state_e;

    typedef struct packed {
        logic       start;
        logic       stop;
        logic       byte_valid;
        logic [7:0] data;
    } i2c_rx_s;
endpackage
`default_nettype wire

// file: hdl/crc16_step.sv
`default_nettype none
module crc16_step (
    input  wire logic [15:0] i_crc,
    input  wire logic [7:0]  i_byte,
    output logic      [15:0] o_crc
);
    import cmd_engine_pkg::*;

    logic [15:0] c;

    // reflected form, one byte per call, lsb first
    always_comb begin
        c = i_crc ^ {8'h00, i_byte};
        for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        o_crc = c;
    end
endmodule
`default_nettype wire

// file: hdl/packet_buffer.sv
`default_nettype none
module packet_buffer #(
    parameter int unsigned DEPTH = 22
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_we,
    input  wire cmd_engine_pkg::idx_t  i_waddr,
    input  wire logic [7:0]            i_wdata,
    input  wire cmd_engine_pkg::idx_t  i_raddr,
    output logic      [7:0]            o_rdata
);
    import cmd_engine_pkg::*;

    logic [7:0] mem [DEPTH];

    // data storage only, so no reset is needed
    always_ff @(posedge i_clk) begin
        if (i_we && (int'(i_waddr) < DEPTH)) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = (int'(i_raddr) < DEPTH) ? mem[i_raddr] : 8'h00;
endmodule
`default_nettype wire

// file: hdl/i2c_packet_command_engine.sv
// Behaviour
// [RULE1] packets are type, count, payload, then two check bytes
// [RULE2] count gives payload length; only zero through eighteen valid
// [RULE3] check value is 16-bit crc over all other bytes, verified
// [RULE4] check value follows last payload byte, low byte first
// [RULE5] only the bus master starts transfers; device only answers
// [RULE6] after a command write, execute it and place reply in output buffer
// [RULE7] host waits about 5 ms before reading most replies
// [RULE8] host waits up to 50 ms for slow commands
// [RULE9] each accepted command gets exactly one reply or error packet
// [RULE10] reply type low six bits equal command type low six bits
// [RULE11] echo command 0x00 accepts count zero to sixteen, any content
// [RULE12] echo reply type 0x40 returns count and payload unchanged
// [RULE13] command 0x01 empty returns 0x41 with sixteen byte version text
// [RULE14] command 0x02 takes exactly sixteen bytes, stores them, replies 0x42
// [RULE15] host waits up to 25 ms after command 0x02
// [RULE16] command 0x03 empty returns 0x43 with stored sixteen bytes
// [RULE17] host should wait for latest reply before sending another
// [RULE18] reading past the reply repeats its last byte
// [RULE19] nak the byte filling last input slot and discard all after
// [RULE20] answer at seven-bit address 0x2A until reconfigured
// [RULE21] bad check value or count is never executed nor answered normally
// [RULE22] crc is reflected ccitt, 0x8408, init all ones, inverted result
`default_nettype none
module i2c_packet_command_engine (
    input  wire logic                     i_clk,
    input  wire logic                     i_srst,
    input  wire cmd_engine_pkg::i2c_rx_s  i_rx,
    output logic                          o_ack,
    input  wire logic                     i_tx_taken,
    output logic      [7:0]               o_tx_data,
    input  wire logic                     i_addr_set,
    input  wire logic [6:0]               i_addr_new,
    output logic                          o_busy,
    output logic                          o_reply_ready
);
    import cmd_engine_pkg::*;

    // bus-facing state
    logic [6:0] addr_reg;
    logic       expect_addr_reg;
    logic       sel_wr_reg;
    logic       sel_rd_reg;
    idx_t       wr_cnt_reg;
    idx_t       wr_cnt_next;
    idx_t       rd_ptr_reg;
    idx_t       rd_ptr_next;
    logic [7:0] tx_data_reg;

    // engine state
    eng_state_e state_reg;
    eng_state_e state_next;
    idx_t       idx_reg;
    idx_t       idx_next;
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;
    logic [7:0] len_reg;
    logic [7:0] len_next;
    logic [15:0] crc_reg;
    logic [15:0] crc_next;
    logic       crc_lo_ok_reg;
    logic       crc_lo_ok_next;
    logic       busy_reg;
    logic       busy_next;
    logic       ready_reg;
    logic       ready_next;
    idx_t       out_cnt_reg;
    idx_t       out_cnt_next;
    logic [7:0] user_mem [USER_BYTES];

    // bus byte decode
    wire        addr_byte = i_rx.byte_valid & expect_addr_reg;
    wire        addr_hit  = (i_rx.data[7:1] == addr_reg);                        // [RULE20]
    wire        hit_wr    = addr_byte & addr_hit & ~i_rx.data[0];
    wire        hit_rd    = addr_byte & addr_hit & i_rx.data[0];
    wire        data_byte = i_rx.byte_valid & ~expect_addr_reg & sel_wr_reg;
    // no new packet while one is in work, so the host must pace itself
    wire        room_ok   = ~busy_reg & (wr_cnt_reg < BUF_LAST);                 // [RULE19] [RULE17]
    wire        store_ok  = ~busy_reg & (wr_cnt_reg <= BUF_LAST);                // [RULE19]
    wire        in_we     = data_byte & store_ok;
    wire        launch    = i_rx.stop & sel_wr_reg & ~busy_reg & (wr_cnt_reg != IDX_ZERO);

    // only bytes addressed to us are acknowledged; nothing is ever initiated here
    assign o_ack = addr_byte ? addr_hit : (data_byte & room_ok);                 // [RULE5] [RULE19]

    // buffers
    wire  [7:0] in_rd;
    wire  [7:0] out_rd;
    logic       out_we;
    logic [7:0] out_wdata;
    wire  [7:0] crc_byte;
    wire [15:0] crc_step;
    wire [15:0] crc_fin = ~crc_reg;                                              // [RULE22]

    packet_buffer #(
        .DEPTH(BUF_DEPTH)
    ) u_in_buf (
        .i_clk   (i_clk),
        .i_we    (in_we),
        .i_waddr (wr_cnt_reg),
        .i_wdata (i_rx.data),
        .i_raddr (idx_reg),
        .o_rdata (in_rd)
    );

    packet_buffer #(
        .DEPTH(BUF_DEPTH)
    ) u_out_buf (
        .i_clk   (i_clk),
        .i_we    (out_we),
        .i_waddr (idx_reg),
        .i_wdata (out_wdata),
        .i_raddr (rd_ptr_reg),
        .o_rdata (out_rd)
    );

    crc16_step u_crc (
        .i_crc  (crc_reg),
        .i_byte (crc_byte),
        .o_crc  (crc_step)
    );

    // length and framing checks
    wire  [7:0] cur_len  = (idx_reg == IDX_ONE) ? in_rd : len_reg;
    wire        hdr_end  = (idx_reg == (cur_len[4:0] + IDX_ONE));                // [RULE1]
    wire        len_bad  = (in_rd > MAX_LEN)
                         | ({3'h0, wr_cnt_reg} < (in_rd + FRAME_EXTRA));         // [RULE2]
    wire        crc_ok   = crc_lo_ok_reg & (in_rd == crc_fin[15:8]);             // [RULE3]

    // command decode
    wire        is_ping  = (cmd_reg == CMD_PING) & (len_reg <= PING_MAX_LEN);    // [RULE11]
    wire        is_ver   = (cmd_reg == CMD_VERSION) & (len_reg == ZERO_LEN);     // [RULE13]
    wire        is_wr    = (cmd_reg == CMD_USER_WR) & (len_reg == BLOCK_LEN);    // [RULE14]
    wire        is_rd    = (cmd_reg == CMD_USER_RD) & (len_reg == ZERO_LEN);     // [RULE16]
    wire        cmd_ok   = is_ping | is_ver | is_wr | is_rd;
    // unknown or misshaped commands get an error packet, never a normal one
    wire  [7:0] resp_type = (cmd_reg & TYPE_LOW) | (cmd_ok ? RESP_FLAG : ERR_FLAG); // [RULE10] [RULE21]
    wire  [7:0] resp_len  = is_ping ? len_reg :
                            (is_ver | is_rd) ? BLOCK_LEN : ZERO_LEN;             // [RULE12]
    wire        build_end = (idx_reg == (resp_len[4:0] + IDX_ONE));

    // payload sources
    wire  [3:0] pay_idx   = 4'(idx_reg - IDX_PAY0);
    wire [127:0] ver_shift = VERSION_STR << {pay_idx, 3'b000};
    wire  [7:0] ver_byte  = ver_shift[127:120];                                  // [RULE13]
    wire  [7:0] pay_byte  = is_ping ? in_rd :                                    // [RULE12]
                            is_ver  ? ver_byte :
                            is_rd   ? user_mem[pay_idx] : 8'h00;                 // [RULE16]
    wire  [7:0] build_byte = (idx_reg == IDX_ZERO) ? resp_type :
                             (idx_reg == IDX_ONE)  ? resp_len  : pay_byte;       // [RULE1]

    assign crc_byte = (state_reg == ST_BUILD) ? build_byte : in_rd;

    always_comb begin
        out_we    = 1'b0;
        out_wdata = build_byte;
        case (state_reg)
            ST_BUILD: begin
                out_we = 1'b1;
            end
            ST_PUT_LO: begin
                out_we    = 1'b1;
                out_wdata = crc_fin[7:0];                                        // [RULE4]
            end
            ST_PUT_HI: begin
                out_we    = 1'b1;
                out_wdata = crc_fin[15:8];                                       // [RULE4]
            end
            default: begin
                out_we = 1'b0;
            end
        endcase
    end

    // engine sequencing
    always_comb begin
        state_next     = state_reg;
        idx_next       = idx_reg;
        cmd_next       = cmd_reg;
        len_next       = len_reg;
        crc_next       = crc_reg;
        crc_lo_ok_next = crc_lo_ok_reg;
        busy_next      = busy_reg;
        ready_next     = ready_reg;
        out_cnt_next   = out_cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (launch) begin                                                // [RULE6]
                    state_next = ST_CHECK;
                    idx_next   = IDX_ZERO;
                    crc_next   = CRC_INIT;                                       // [RULE22]
                    busy_next  = 1'b1;
                    ready_next = 1'b0;
                end
            end
            ST_CHECK: begin
                crc_next = crc_step;                                             // [RULE3]
                idx_next = idx_reg + IDX_ONE;
                if (idx_reg == IDX_ZERO) begin
                    cmd_next = in_rd;
                end
                if ((idx_reg == IDX_ONE) && len_bad) begin                       // [RULE21]
                    state_next = ST_IDLE;
                    busy_next  = 1'b0;
                end else begin
                    if (idx_reg == IDX_ONE) begin
                        len_next = in_rd;
                    end
                    if (hdr_end) begin
                        state_next = ST_CRC_LO;
                    end
                end
            end
            ST_CRC_LO: begin
                crc_lo_ok_next = (in_rd == crc_fin[7:0]);                        // [RULE4]
                idx_next       = idx_reg + IDX_ONE;
                state_next     = ST_CRC_HI;
            end
            ST_CRC_HI: begin
                if (!crc_ok) begin                                               // [RULE21]
                    state_next = ST_IDLE;
                    busy_next  = 1'b0;
                end else if (is_wr) begin
                    state_next = ST_STORE;
                    idx_next   = IDX_PAY0;
                end else begin
                    state_next = ST_BUILD;
                    idx_next   = IDX_ZERO;
                    crc_next   = CRC_INIT;
                end
            end
            ST_STORE: begin
                idx_next = idx_reg + IDX_ONE;
                if (idx_reg == USER_LAST) begin
                    state_next = ST_BUILD;
                    idx_next   = IDX_ZERO;
                    crc_next   = CRC_INIT;
                end
            end
            ST_BUILD: begin
                crc_next = crc_step;                                             // [RULE3]
                idx_next = idx_reg + IDX_ONE;
                if (build_end) begin
                    state_next = ST_PUT_LO;
                end
            end
            ST_PUT_LO: begin
                idx_next   = idx_reg + IDX_ONE;
                state_next = ST_PUT_HI;
            end
            ST_PUT_HI: begin
                // one reply per accepted packet, published only when complete
                out_cnt_next = idx_reg + IDX_ONE;                                // [RULE9]
                state_next   = ST_IDLE;
                busy_next    = 1'b0;
                ready_next   = 1'b1;
            end
            default: begin
                state_next = ST_IDLE;
                busy_next  = 1'b0;
            end
        endcase
    end

    // bus counters
    always_comb begin
        wr_cnt_next = wr_cnt_reg;
        if (hit_wr && !busy_reg) begin
            wr_cnt_next = IDX_ZERO;
        end else if (in_we) begin
            wr_cnt_next = wr_cnt_reg + IDX_ONE;
        end
        rd_ptr_next = rd_ptr_reg;
        if (hit_rd) begin
            rd_ptr_next = IDX_ZERO;
        end else if (i_tx_taken && sel_rd_reg
                     && ((rd_ptr_reg + IDX_ONE) < out_cnt_reg)) begin            // [RULE18]
            rd_ptr_next = rd_ptr_reg + IDX_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            addr_reg        <= DEFAULT_ADDR;                                     // [RULE20]
            expect_addr_reg <= 1'b0;
            sel_wr_reg      <= 1'b0;
            sel_rd_reg      <= 1'b0;
        end else begin
            if (i_addr_set) begin
                addr_reg <= i_addr_new;
            end
            if (i_rx.start) begin
                expect_addr_reg <= 1'b1;
                sel_wr_reg      <= 1'b0;
                sel_rd_reg      <= 1'b0;
            end else if (i_rx.stop) begin
                expect_addr_reg <= 1'b0;
                sel_wr_reg      <= 1'b0;
                sel_rd_reg      <= 1'b0;
            end else if (addr_byte) begin
                expect_addr_reg <= 1'b0;
                sel_wr_reg      <= hit_wr;
                sel_rd_reg      <= hit_rd;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_cnt_reg  <= IDX_ZERO;
            rd_ptr_reg  <= IDX_ZERO;
            tx_data_reg <= 8'h00;
        end else begin
            wr_cnt_reg  <= wr_cnt_next;
            rd_ptr_reg  <= rd_ptr_next;
            tx_data_reg <= out_rd;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_reg     <= ST_IDLE;
            idx_reg       <= IDX_ZERO;
            cmd_reg       <= 8'h00;
            len_reg       <= 8'h00;
            crc_reg       <= CRC_INIT;
            crc_lo_ok_reg <= 1'b0;
            busy_reg      <= 1'b0;
            ready_reg     <= 1'b0;
            out_cnt_reg   <= IDX_ZERO;
        end else begin
            state_reg     <= state_next;
            idx_reg       <= idx_next;
            cmd_reg       <= cmd_next;
            len_reg       <= len_next;
            crc_reg       <= crc_next;
            crc_lo_ok_reg <= crc_lo_ok_next;
            busy_reg      <= busy_next;
            ready_reg     <= ready_next;
            out_cnt_reg   <= out_cnt_next;
        end
    end

    // flops stand in for the nonvolatile area; contents survive only until reset
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int k = 0; k < USER_BYTES; k++) begin
                user_mem[k] <= 8'h00;
            end
        end else if (state_reg == ST_STORE) begin
            user_mem[pay_idx] <= in_rd;                                          // [RULE14]
        end
    end

    assign o_tx_data     = tx_data_reg;
    assign o_busy        = busy_reg;
    assign o_reply_ready = ready_reg;
endmodule
`default_nettype wire

// file: hdl/unused_placeholder_never.sv
`default_nettype none
`default_nettype wire

// file: test/cmd_engine_checker.sv
`default_nettype none
module cmd_engine_checker (
    input  wire logic                    i_clk,
    input  wire logic                    i_srst,
    input  wire cmd_engine_pkg::i2c_rx_s i_rx,
    input  wire logic                    o_ack,
    input  wire logic                    i_tx_taken,
    input  wire logic [7:0]              o_tx_data,
    input  wire logic                    i_addr_set,
    input  wire logic [6:0]              i_addr_new,
    input  wire logic                    o_busy,
    input  wire logic                    o_reply_ready
);
    import cmd_engine_pkg::*;
    logic       first_reg;
    logic       wr_reg;
    logic [4:0] cnt_reg;
    logic [6:0] addr_reg;
    logic [1:0] quiet_reg;
    wire logic  addr_byte = i_rx.byte_valid && first_reg;
    wire logic  data_byte = i_rx.byte_valid && !first_reg;
    wire logic  addr_hit  = i_rx.data[7:1] == addr_reg;
    wire logic  stir      = i_tx_taken || i_rx.byte_valid || o_busy;

    // counts data bytes per transfer; saturates so long floods stay refused
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            first_reg <= 1'b0;
            wr_reg    <= 1'b0;
            cnt_reg   <= 5'h00;
            addr_reg  <= DEFAULT_ADDR;
            quiet_reg <= 2'h0;
        end else begin
            first_reg <= i_rx.start || (first_reg && !i_rx.byte_valid);
            if (addr_byte) wr_reg <= addr_hit && !i_rx.data[0];
            if (addr_byte) cnt_reg <= 5'h00;
            else if (data_byte && cnt_reg != 5'h1F) cnt_reg <= cnt_reg + 5'h01;
            if (i_addr_set) addr_reg <= i_addr_new;
            quiet_reg <= stir ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    sequence finish_s;
        ##[1:80] !o_busy;
    endsequence
    sequence ready_up_s;
        $rose(o_reply_ready);
    endsequence

    reset_quiet_a: assert property (i_srst |=> !o_busy && !o_reply_ready && o_tx_data == 8'h00)
        else $error("outputs not idle after reset");
    busy_excl_a: assert property (disable iff (i_srst) !(o_busy && o_reply_ready))
        else $error("busy and reply ready together");
    ready_src_a: assert property (disable iff (i_srst) ready_up_s |-> $past(o_busy))
        else $error("reply ready without prior work");
    launch_stop_a: assert property (disable iff (i_srst) $rose(o_busy) |-> $past(i_rx.stop) || $past(i_rx.stop, 2))
        else $error("work started without stop");
    busy_end_a: assert property (disable iff (i_srst) $rose(o_busy) |-> finish_s)
        else $error("work never finished");
    addr_ack_a: assert property (disable iff (i_srst) addr_byte && addr_hit |-> o_ack)
        else $error("own address not acknowledged");
    addr_nak_a: assert property (disable iff (i_srst) addr_byte && !addr_hit |-> !o_ack)
        else $error("foreign address acknowledged");
    fill_ack_a: assert property (disable iff (i_srst) data_byte && wr_reg && !o_busy && cnt_reg < 5'h15 |-> o_ack)
        else $error("storable byte refused");
    overflow_a: assert property (disable iff (i_srst) data_byte && cnt_reg >= 5'h15 |-> !o_ack)
        else $error("byte past buffer acknowledged");
    busy_nak_a: assert property (disable iff (i_srst) data_byte && o_busy |-> !o_ack)
        else $error("byte acknowledged while busy");
    hold_a: assert property (disable iff (i_srst) quiet_reg == 2'h3 |=> $stable(o_tx_data))
        else $error("read byte changed without advance");
endmodule
`default_nettype wire

// file: test/host_model.sv
`default_nettype none
module host_model (
    input  wire logic                    i_clk,
    output var cmd_engine_pkg::i2c_rx_s  o_rx,
    output logic                         o_tx_taken,
    input  wire logic                    i_ack,
    input  wire logic [7:0]              i_tx_data
);
    timeunit 1ns;
    timeprecision 100ps;
    import cmd_engine_pkg::*;
    initial begin
        o_rx = '0;
        o_rx.data = 8'hA5;
        o_tx_taken = 1'b0;
    end
    task automatic cond(input logic is_stop);
        @(negedge i_clk);
        o_rx.start = !is_stop;
        o_rx.stop = is_stop;
        @(negedge i_clk);
        o_rx.start = 1'b0;
        o_rx.stop = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic a);
        @(negedge i_clk);
        o_rx.data = b;
        o_rx.byte_valid = 1'b1;
        #1 a = i_ack;
        @(negedge i_clk);
        o_rx.byte_valid = 1'b0;
        // no stale byte left on the lines between transfers
        o_rx.data = ~b;
    endtask
    task automatic get_byte(output logic [7:0] b);
        b = i_tx_data;
        @(negedge i_clk);
        o_tx_taken = 1'b1;
        @(negedge i_clk);
        o_tx_taken = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// file: test/i2c_packet_command_engine_bench.sv
`default_nettype none
module i2c_packet_command_engine_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cmd_engine_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_srst = 1'b1;
    logic       addr_set = 1'b0;
    logic [6:0] addr_new = 7'h00;
    logic [6:0] cur_addr = DEFAULT_ADDR;
    i2c_rx_s    rx;
    logic       ack, taken, busy, ready;
    logic [7:0] tx_data;
    logic [7:0] pkt[$];
    logic [7:0] exp[$];
    int         mismatches = 0;
    int         total_checks = 0;

    always #5 i_clk = ~i_clk;

    i2c_packet_command_engine dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_rx(rx), .o_ack(ack), .i_tx_taken(taken),
        .o_tx_data(tx_data), .i_addr_set(addr_set), .i_addr_new(addr_new),
        .o_busy(busy), .o_reply_ready(ready)
    );
    host_model host (
        .i_clk(i_clk), .o_rx(rx), .o_tx_taken(taken), .i_ack(ack), .i_tx_data(tx_data)
    );

    task automatic check(input string what, input logic [15:0] want, input logic [15:0] seen);
        total_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return ~c;
    endfunction

    task automatic seal();
        logic [15:0] c;
        c = crc16(pkt);
        pkt.push_back(c[7:0]);
        pkt.push_back(c[15:8]);
        if (exp.size() > 0) begin
            c = crc16(exp);
            exp.push_back(c[7:0]);
            exp.push_back(c[15:8]);
        end
    endtask

    task automatic write_pkt(input logic busy_now);
        logic a;
        host.cond(1'b0);
        host.put_byte({cur_addr, 1'b0}, a);
        check("write address ack", 1, a);
        foreach (pkt[i]) begin
            host.put_byte(pkt[i], a);
            check("data ack", !busy_now && i < 21, a);
        end
        host.cond(1'b1);
    endtask

    // polls instead of fixed host delays, so no reply is overrun
    task automatic await_reply();
        int n = 0;
        repeat (3) @(negedge i_clk);
        while (busy !== 1'b0 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        check("engine finished", 1, n < 200);
    endtask

    task automatic read_reply(input int extra);
        logic a;
        logic [7:0] b;
        check("reply ready", 1, ready);
        host.cond(1'b0);
        host.put_byte({cur_addr, 1'b1}, a);
        check("read address ack", 1, a);
        repeat (3) @(negedge i_clk);
        for (int i = 0; i < exp.size() + extra; i++) begin
            host.get_byte(b);
            check("reply byte", exp[i < exp.size() ? i : exp.size() - 1], b);
        end
        host.cond(1'b1);
    endtask

    task automatic t_echo(input logic [7:0] len, input logic poke);
        pkt = {CMD_PING, len};
        for (int i = 0; i < len; i++) pkt.push_back(8'h30 + 8'(i * 13));
        exp = pkt;
        exp[0] = 8'h40;
        seal();
        write_pkt(1'b0);
        if (poke) begin
            pkt = {8'hEE};
            write_pkt(1'b1);
        end
        await_reply();
        read_reply(2);
        $display("test echo length %0d done", len);
    endtask

    task automatic t_version();
        pkt = {CMD_VERSION, ZERO_LEN};
        exp = {8'h41, 8'h10};
        for (int i = 15; i >= 0; i--) exp.push_back(VERSION_STR[i*8 +: 8]);
        seal();
        write_pkt(1'b0);
        await_reply();
        read_reply(0);
        $display("test version done");
    endtask

    task automatic t_user();
        logic [7:0] keep[$];
        pkt = {CMD_USER_WR, BLOCK_LEN};
        for (int i = 0; i < 16; i++) pkt.push_back(8'hF0 - 8'(i * 5));
        keep = pkt[2:17];
        exp = {8'h42, 8'h00};
        seal();
        write_pkt(1'b0);
        await_reply();
        read_reply(0);
        pkt = {CMD_USER_RD, ZERO_LEN};
        exp = {8'h43, 8'h10, keep};
        seal();
        write_pkt(1'b0);
        await_reply();
        read_reply(1);
        $display("test user area done");
    endtask

    task automatic t_errors();
        logic [7:0] bad[4] = '{8'h01, 8'h03, 8'h02, 8'h05};
        for (int k = 0; k < 4; k++) begin
            pkt = {bad[k], 8'h01, 8'h5A};
            exp = {(bad[k] & TYPE_LOW) | ERR_FLAG, 8'h00};
            seal();
            write_pkt(1'b0);
            await_reply();
            read_reply(0);
        end
        pkt = {CMD_PING, 8'h02, 8'h11, 8'h22};
        exp = {};
        seal();
        pkt[4] = ~pkt[4];
        write_pkt(1'b0);
        await_reply();
        check("no reply to bad check", 0, ready);
        pkt = {CMD_PING, MAX_LEN};
        for (int i = 0; i < 18; i++) pkt.push_back(8'(i));
        exp = {ERR_FLAG, 8'h00};
        seal();
        pkt.push_back(8'h77);
        pkt.push_back(8'h88);
        write_pkt(1'b0);
        await_reply();
        read_reply(0);
        $display("test errors done");
    endtask

    task automatic t_addr();
        logic a;
        host.cond(1'b0);
        host.put_byte(8'h56, a);
        check("foreign address ack", 0, a);
        host.cond(1'b1);
        @(negedge i_clk);
        addr_set = 1'b1;
        addr_new = 7'h33;
        @(negedge i_clk);
        addr_set = 1'b0;
        cur_addr = 7'h33;
        host.cond(1'b0);
        host.put_byte(8'h54, a);
        check("old address ack", 0, a);
        host.cond(1'b1);
        t_echo(8'h01, 1'b0);
        i_srst = 1'b1;
        repeat (5) @(negedge i_clk);
        i_srst = 1'b0;
        cur_addr = DEFAULT_ADDR;
        check("ready after reset", 0, ready);
        t_echo(8'h02, 1'b0);
        $display("test address done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge i_clk);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (5) @(negedge i_clk);
        i_srst = 1'b0;
        t_echo(8'h00, 1'b0);
        t_echo(8'h10, 1'b1);
        t_version();
        t_user();
        t_errors();
        t_addr();
        close_out();
    end
endmodule

bind i2c_packet_command_engine cmd_engine_checker chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_rx(i_rx), .o_ack(o_ack), .i_tx_taken(i_tx_taken),
    .o_tx_data(o_tx_data), .i_addr_set(i_addr_set), .i_addr_new(i_addr_new),
    .o_busy(o_busy), .o_reply_ready(o_reply_ready)
);
`default_nettype wire
